/* File: common/efgm_pkg.sv */
// Constants shared by the exact-frequency and output-mux register bank
package efgm_pkg;
	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 24;
	// Register offsets
	localparam logic [7:0] EXACT_FREQ_COUNT_OFS = 8'h0c;
	localparam logic [7:0] OUTPUT_PIN_CONTROL_OFS = 8'h0f;
	localparam logic [7:0] STATUS_READBACK_OFS = 8'h12;
	// Reset values
	localparam logic [13:0] EXACT_FREQ_COUNT_RST = 14'h0000;
	localparam logic [4:0] GPO_SELECT_RST = 5'h01;
	// Field layout of the exact-frequency count register
	localparam int EFC_W = 14;
	// Field layout of the output pin control register
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 4;
	localparam int TEST_DATA_BIT = 5;
	localparam int NO_AUTOMUX_BIT = 6;
	localparam int DRIVER_ON_BIT = 7;
	localparam int NO_PFET_BIT = 8;
	localparam int NO_NFET_BIT = 9;
	localparam int CTRL_W = 10;
	// Field layout of the status readback register
	localparam int PIN_STATE_BIT = 0;
	localparam int LOCK_BIT = 1;
	// Feedback divider widths and exact-count constants
	localparam int NINT_W = 20;
	localparam int FRAC_W = 24;
	localparam logic [13:0] EFC_FIRST_ON = 14'h0002;
	localparam logic [13:0] EFC_ONE = 14'h0001;
	// Output source select codes
	localparam logic [4:0] SEL_TEST_DATA = 5'h00;
	localparam logic [4:0] SEL_LOCK = 5'h01;
	localparam logic [4:0] SEL_LOCK_WINDOW = 5'h02;
	localparam logic [4:0] SEL_RING_OSC = 5'h04;
	localparam logic [4:0] SEL_SLIP_UP = 5'h05;
	localparam logic [4:0] SEL_SLIP_DN = 5'h06;
	localparam logic [4:0] SEL_REF_BUF = 5'h08;
	localparam logic [4:0] SEL_OUT_DIV = 5'h0a;
	localparam logic [4:0] SEL_MOD_CLK = 5'h0b;
	localparam logic [4:0] SEL_AUX_CLK = 5'h0c;
	localparam logic [4:0] SEL_AUX_SCLK = 5'h0d;
	localparam logic [4:0] SEL_AUX_SEN = 5'h0e;
	localparam logic [4:0] SEL_AUX_SDAT = 5'h0f;
	localparam logic [4:0] SEL_DET_DN = 5'h10;
	localparam logic [4:0] SEL_DET_UP = 5'h11;
	localparam logic [4:0] SEL_MOD_DLY = 5'h12;
	localparam logic [4:0] SEL_MOD_CORE = 5'h13;
	localparam logic [4:0] SEL_STB_INT = 5'h14;
	localparam logic [4:0] SEL_STB_FRAC = 5'h15;
	localparam logic [4:0] SEL_STB_AUX = 5'h16;
	localparam logic [4:0] SEL_LATCH_EN = 5'h17;
	localparam logic [4:0] SEL_DIV_SYNC = 5'h18;
	localparam logic [4:0] SEL_SEED_LOAD = 5'h19;
	localparam logic [4:0] SEL_SER_OE = 5'h1e;
	localparam logic [4:0] SEL_SOFT_RST = 5'h1f;
	localparam int NUM_SEL = 32;

	// Exact mode is on for counts 2 and above; 0 and 1 leave it off
	function automatic logic efgm_exact_on(input logic [13:0] count);
		return count >= EFC_FIRST_ON;
	endfunction
endpackage

/* File: core/efgm_exact_mod.sv */
// Fractional feedback divider sequencer with exact-frequency period reset
`timescale 1ns/1ps
module efgm_exact_mod import efgm_pkg::*; (
	input wire logic core_clk, // Register clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic pfd_tick, // One pulse per comparison cycle
	input wire logic [NINT_W-1:0] feedback_int, // Integer part of the ratio
	input wire logic [FRAC_W-1:0] feedback_frac, // Fraction in units of 2^-24
	input wire logic [EFC_W-1:0] exact_freq_count, // Channels per comparison period
	output logic [NINT_W-1:0] div_value, // Divide value for this cycle
	output logic div_valid // Pulse with each new divide value
);
	logic [FRAC_W-1:0] acc;
	logic [EFC_W-1:0] chan_cnt;
	logic [FRAC_W:0] next_sum;
	logic carry;
	logic exact_on;
	logic period_end;

	// First-order accumulation of the 24-bit fraction
	assign next_sum = {1'b0, acc} + {1'b0, feedback_frac};
	assign carry = next_sum[FRAC_W];
	assign exact_on = efgm_exact_on(exact_freq_count);
	// Residue is discarded each period so the average is the exact ratio
	// A count lowered mid-period ends the period at once instead of after a wrap
	assign period_end = exact_on && (chan_cnt >= exact_freq_count - EFC_ONE);

	// Accumulator and channel counter
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			acc <= '0;
			chan_cnt <= '0;
		end else if (pfd_tick) begin
			acc <= period_end ? '0 : next_sum[FRAC_W-1:0];
			chan_cnt <= (period_end || !exact_on) ? '0 : chan_cnt + EFC_ONE;
		end
	end

	// Integer part plus carry gives this cycle's divide value
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			div_value <= '0;
			div_valid <= 1'b0;
		end else begin
			div_value <= feedback_int + {{(NINT_W-1){1'b0}}, carry};
			div_valid <= pfd_tick;
		end
	end
endmodule

/* File: core/efgm_top.sv */
// Exact-frequency count register, output pin control and output source mux
// How it works
// - Output divide ratio is even only; host picks twice floor of fmax over 2*fout.
// - Feedback ratio is integer part plus 24-bit fraction over 2^24.
// - Host writes reduced denominator into exact count; device then gives exact ratio.
// - Exact count is 14 bits; 0 and 1 disable, 2 to 16383 enable.
// - With exact count on, multiples of the correction rate have zero error.
// - Pin driver off after reset; drives only during serial reads to us unless control bit 7 is set.
// - Control bit 7 keeps the pin driver on permanently for monitoring.
// - Five-bit select picks the pin source; resets to 1, lock detect.
// - Codes 0-12 other than 3, 7 and 9 pick test bit, lock, window, oscillator, slip, buffers, clocks; 3, 7 and 9 drive low.
// - Codes 13-25 and 30-31 pick serial, detector, modulator clock, strobe and reset signals.
// - Lock status reads 1 when locked and 0 when unlocked.
`timescale 1ns/1ps
module efgm_top import efgm_pkg::*; (
	input wire logic core_clk, // 100 MHz register clock
	input wire logic nrst, // Synchronous reset, active low
	// Register access from the serial port
	input wire logic reg_wr_en, // Write strobe, one cycle
	input wire logic reg_rd_en, // Read strobe, one cycle
	input wire logic [ADDR_W-1:0] reg_addr, // Register offset
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	output logic [DATA_W-1:0] reg_rdata, // Read data, valid cycle after strobe
	output logic reg_rvalid, // Read data valid pulse
	// Serial read in progress and its data
	input wire logic ser_read_active, // Addressed serial read under way
	input wire logic ser_data_out, // Serial read data bit
	// Shared lock/serial-out pin
	input wire logic lock_serial_out_pin_in, // Pin level as seen on the wire
	output logic lock_serial_out_pin_out, // Pin drive level
	output logic lock_serial_out_pin_oe_n, // Low while the pin is driven
	output logic pin_pfet_off, // Pull-up half of driver disabled
	output logic pin_nfet_off, // Pull-down half of driver disabled
	// Feedback divider
	input wire logic pfd_tick, // One pulse per comparison cycle
	input wire logic [NINT_W-1:0] feedback_int, // Integer part of ratio
	input wire logic [FRAC_W-1:0] feedback_frac, // Fractional part of ratio
	output logic [NINT_W-1:0] feedback_divide_ratio, // Divide value per cycle
	output logic feedback_div_valid, // Pulse with each divide value
	// Internal signals offered on the pin
	input wire logic lock_detect, // Loop locked
	input wire logic lock_window, // Lock detect window
	input wire logic ring_osc, // Ring oscillator test
	input wire logic slip_pull_up, // Cycle slip prevention pull up
	input wire logic slip_pull_dn, // Cycle slip prevention pull down
	input wire logic ref_buf_out, // Reference buffer output
	input wire logic out_div_out, // Output divider output
	input wire logic mod_clk, // Modulator clock from output divider
	input wire logic aux_clk, // Auxiliary clock
	input wire logic aux_ser_clk, // Auxiliary serial clock
	input wire logic aux_ser_en, // Auxiliary serial enable
	input wire logic aux_ser_data, // Auxiliary serial data out
	input wire logic det_dn, // Phase detector down
	input wire logic det_up, // Phase detector up
	input wire logic mod_clk_dly, // Modulator clock delay
	input wire logic mod_core_clk, // Modulator core clock
	input wire logic strobe_int_wr, // Integer write autostrobe
	input wire logic strobe_frac_wr, // Fraction write autostrobe
	input wire logic strobe_aux_wr, // Auxiliary serial autostrobe
	input wire logic ser_latch_en, // Serial latch enable
	input wire logic div_sync_rst, // Divider sync reset
	input wire logic seed_load, // Seed load strobe
	input wire logic ser_out_en, // Serial output buffer enable
	input wire logic soft_rst_n // Soft reset, active low
);
	////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [EFC_W-1:0] exact_freq_count;
	logic [CTRL_W-1:0] output_pin_control;
	logic pin_sync1;
	logic pin_sync2;

	// Address decode
	wire hit_efc = (reg_addr == EXACT_FREQ_COUNT_OFS);
	wire hit_ctrl = (reg_addr == OUTPUT_PIN_CONTROL_OFS);
	wire hit_stat = (reg_addr == STATUS_READBACK_OFS);
	wire wr_efc = reg_wr_en && hit_efc;
	wire wr_ctrl = reg_wr_en && hit_ctrl;

	// Control fields
	wire [4:0] gpo_select = output_pin_control[SEL_MSB:SEL_LSB];
	wire gpo_test_data = output_pin_control[TEST_DATA_BIT];
	wire no_automux = output_pin_control[NO_AUTOMUX_BIT];
	wire driver_always_on = output_pin_control[DRIVER_ON_BIT];

	// Exact count register, reserved upper bits not stored
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			exact_freq_count <= EXACT_FREQ_COUNT_RST;
		end else if (wr_efc) begin
			exact_freq_count <= reg_wdata[EFC_W-1:0];
		end
	end

	// Output pin control register, select resets to lock detect
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			output_pin_control <= {{(CTRL_W-5){1'b0}}, GPO_SELECT_RST};
		end else if (wr_ctrl) begin
			output_pin_control <= reg_wdata[CTRL_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin level synchroniser for the readback of the wire state
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
		end else begin
			pin_sync1 <= lock_serial_out_pin_in;
			pin_sync2 <= pin_sync1;
		end
	end

	// Read data selection; unmapped offsets read zero
	wire [DATA_W-1:0] rd_efc = {{(DATA_W-EFC_W){1'b0}}, exact_freq_count};
	wire [DATA_W-1:0] rd_ctrl = {{(DATA_W-CTRL_W){1'b0}}, output_pin_control};
	wire [DATA_W-1:0] rd_stat = {{(DATA_W-2){1'b0}}, lock_detect, pin_sync2};
	wire [DATA_W-1:0] rd_mux = hit_efc ? rd_efc :
		hit_ctrl ? rd_ctrl :
		hit_stat ? rd_stat : '0;

	// Registered read answer
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_rd_en ? rd_mux : reg_rdata;
			reg_rvalid <= reg_rd_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output source vector indexed by the select code
	wire [NUM_SEL-1:0] gpo_src;
	assign gpo_src[SEL_TEST_DATA] = gpo_test_data;
	assign gpo_src[SEL_LOCK] = lock_detect;
	assign gpo_src[SEL_LOCK_WINDOW] = lock_window;
	assign gpo_src[3] = 1'b0;
	assign gpo_src[SEL_RING_OSC] = ring_osc;
	assign gpo_src[SEL_SLIP_UP] = slip_pull_up;
	assign gpo_src[SEL_SLIP_DN] = slip_pull_dn;
	assign gpo_src[7] = 1'b0;
	assign gpo_src[SEL_REF_BUF] = ref_buf_out;
	assign gpo_src[9] = 1'b0;
	assign gpo_src[SEL_OUT_DIV] = out_div_out;
	assign gpo_src[SEL_MOD_CLK] = mod_clk;
	assign gpo_src[SEL_AUX_CLK] = aux_clk;
	assign gpo_src[SEL_AUX_SCLK] = aux_ser_clk;
	assign gpo_src[SEL_AUX_SEN] = aux_ser_en;
	assign gpo_src[SEL_AUX_SDAT] = aux_ser_data;
	assign gpo_src[SEL_DET_DN] = det_dn;
	assign gpo_src[SEL_DET_UP] = det_up;
	assign gpo_src[SEL_MOD_DLY] = mod_clk_dly;
	assign gpo_src[SEL_MOD_CORE] = mod_core_clk;
	assign gpo_src[SEL_STB_INT] = strobe_int_wr;
	assign gpo_src[SEL_STB_FRAC] = strobe_frac_wr;
	assign gpo_src[SEL_STB_AUX] = strobe_aux_wr;
	assign gpo_src[SEL_LATCH_EN] = ser_latch_en;
	assign gpo_src[SEL_DIV_SYNC] = div_sync_rst;
	assign gpo_src[SEL_SEED_LOAD] = seed_load;
	assign gpo_src[29:26] = 4'h0;
	assign gpo_src[SEL_SER_OE] = ser_out_en;
	assign gpo_src[SEL_SOFT_RST] = soft_rst_n;

	wire gpo_level = gpo_src[gpo_select];

	// Serial data takes the pin during reads unless automux is blocked
	wire show_ser = ser_read_active && !no_automux;
	wire next_pin_out = show_ser ? ser_data_out : gpo_level;
	// Driver on during addressed reads, or always when monitoring
	wire next_pin_drive = ser_read_active || driver_always_on;

	// Pin drive registers; driver released while in reset
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			lock_serial_out_pin_out <= 1'b0;
			lock_serial_out_pin_oe_n <= 1'b1;
		end else begin
			lock_serial_out_pin_out <= next_pin_out;
			lock_serial_out_pin_oe_n <= !next_pin_drive;
		end
	end

	// Driver half disables come straight from their control bits
	assign pin_pfet_off = output_pin_control[NO_PFET_BIT];
	assign pin_nfet_off = output_pin_control[NO_NFET_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Feedback divider sequencer with exact-frequency correction
	efgm_exact_mod u_exact_mod (
		.core_clk(core_clk),
		.nrst(nrst),
		.pfd_tick(pfd_tick),
		.feedback_int(feedback_int),
		.feedback_frac(feedback_frac),
		.exact_freq_count(exact_freq_count),
		.div_value(feedback_divide_ratio),
		.div_valid(feedback_div_valid)
	);
endmodule

/* File: verif/efgm_asserts.sv */
// Checker for the exact-count register, pin control and divider outputs
`timescale 1ns/1ps
module efgm_checker import efgm_pkg::*; (
	input wire logic core_clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic reg_wr_en, // Write strobe
	input wire logic reg_rd_en, // Read strobe
	input wire logic [ADDR_W-1:0] reg_addr, // Offset
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	input wire logic [DATA_W-1:0] reg_rdata, // Read data
	input wire logic reg_rvalid, // Read valid
	input wire logic ser_read_active, // Serial read
	input wire logic ser_data_out, // Serial bit
	input wire logic lock_serial_out_pin_out, // Pin level
	input wire logic lock_serial_out_pin_oe_n, // Pin enable, low on
	input wire logic pfd_tick, // Comparison tick
	input wire logic [NINT_W-1:0] feedback_int, // Integer part
	input wire logic [NINT_W-1:0] feedback_divide_ratio, // Divide value
	input wire logic feedback_div_valid, // Divide valid
	input wire logic lock_detect // Lock status
);
	logic [9:0] ctrl;
	logic [13:0] efc;
	logic mux_src;
	// Shadow copies of the two writable registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl <= 10'h001;
			efc <= 14'h0000;
		end else if (reg_wr_en && reg_addr == OUTPUT_PIN_CONTROL_OFS) begin
			ctrl <= reg_wdata[9:0];
		end else if (reg_wr_en && reg_addr == EXACT_FREQ_COUNT_OFS) begin
			efc <= reg_wdata[13:0];
		end
	end
	// Source mux reaches the pin unless serial data takes it
	assign mux_src = !ser_read_active || ctrl[6];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	idle_off_a: assert property (!ser_read_active && !ctrl[7] |=> lock_serial_out_pin_oe_n)
		else $error("Pin driven while idle");
	read_drive_a: assert property (ser_read_active && !ctrl[6] |=> !lock_serial_out_pin_oe_n
		&& lock_serial_out_pin_out == $past(ser_data_out))
		else $error("Serial data not driven");
	always_on_a: assert property (ctrl[7] |=> !lock_serial_out_pin_oe_n)
		else $error("Driver not kept on");
	lock_src_a: assert property (mux_src && ctrl[4:0] == SEL_LOCK
		|=> lock_serial_out_pin_out == $past(lock_detect))
		else $error("Lock status not on pin");
	test_bit_a: assert property (mux_src && ctrl[4:0] == SEL_TEST_DATA
		|=> lock_serial_out_pin_out == $past(ctrl[5]))
		else $error("Test bit not on pin");
	unused_low_a: assert property (mux_src && ctrl[4:0] inside {5'h03, 5'h07, 5'h09, [5'h1a:5'h1d]}
		|=> !lock_serial_out_pin_out)
		else $error("Unused code not low");
	count_read_a: assert property (reg_rd_en && reg_addr == EXACT_FREQ_COUNT_OFS
		|=> reg_rvalid && reg_rdata == {10'h000, $past(efc)})
		else $error("Exact count readback wrong");
	ctrl_read_a: assert property (reg_rd_en && reg_addr == OUTPUT_PIN_CONTROL_OFS
		|=> reg_rvalid && reg_rdata == {14'h0000, $past(ctrl)})
		else $error("Pin control readback wrong");
	div_step_a: assert property (pfd_tick |=> feedback_div_valid
		&& feedback_divide_ratio - $past(feedback_int) <= 20'h00001)
		else $error("Divide value out of range");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind efgm_top efgm_checker chk (.core_clk, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
	.reg_rdata, .reg_rvalid, .ser_read_active, .ser_data_out, .lock_serial_out_pin_out,
	.lock_serial_out_pin_oe_n, .pfd_tick, .feedback_int, .feedback_divide_ratio,
	.feedback_div_valid, .lock_detect);

/* File: verif/efgm_host_model.sv */
// Host-side model of an addressed serial read on the shared pin
`timescale 1ns/1ps
module efgm_host_model (
	input wire logic core_clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic start, // Begin an eight-bit read
	input wire logic [7:0] pattern, // Bits sent, MSB first
	output logic ser_read_active, // Read under way
	output logic ser_data_out // Read data bit
);
	logic [3:0] cnt;
	logic last_bit;
	// Count out eight bit times per read
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt <= 4'h0;
			last_bit <= 1'b0;
		end else if (start && cnt == 4'h0) begin
			cnt <= 4'h8;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			last_bit <= ser_data_out;
		end
	end
	// Released data flips so a held value cannot pass for a driven one
	assign ser_read_active = cnt != 4'h0;
	assign ser_data_out = ser_read_active ? pattern[cnt - 4'h1] : ~last_bit;
endmodule

/* File: verif/test_exact_freq_and_gpo_mux.sv */
// Self-checking bench for the exact-count register bank and pin mux
`timescale 1ns/1ps
module test_exact_freq_and_gpo_mux import efgm_pkg::*;;
	logic core_clk = 1'b0, nrst = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0, pfd_tick = 1'b0;
	logic [7:0] reg_addr = 8'h00, pattern = 8'h00;
	logic [23:0] reg_wdata = 24'h000000, src = 24'h000000, fb_frac = 24'h000000, reg_rdata;
	logic [19:0] fb_int = 20'h0002c, fb_ratio; // Ratio 44 stays above the minimum
	logic reg_rvalid, pin_out, pin_oe_n, div_valid, ser_act, ser_dat, pfet_off, nfet_off;
	logic start = 1'b0;
	logic [31:0] sum;
	wire pin_wire = pin_oe_n ? 1'b1 : pin_out;
	int num_errors = 0, total_checks = 0, cycles = 0;
	efgm_top dut (
		.core_clk, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.ser_read_active(ser_act), .ser_data_out(ser_dat), .lock_serial_out_pin_in(pin_wire),
		.lock_serial_out_pin_out(pin_out), .lock_serial_out_pin_oe_n(pin_oe_n),
		.pin_pfet_off(pfet_off), .pin_nfet_off(nfet_off), .pfd_tick,
		.feedback_int(fb_int), .feedback_frac(fb_frac),
		.feedback_divide_ratio(fb_ratio), .feedback_div_valid(div_valid),
		.lock_detect(src[0]), .lock_window(src[1]), .ring_osc(src[2]), .slip_pull_up(src[3]),
		.slip_pull_dn(src[4]), .ref_buf_out(src[5]), .out_div_out(src[6]), .mod_clk(src[7]),
		.aux_clk(src[8]), .aux_ser_clk(src[9]), .aux_ser_en(src[10]), .aux_ser_data(src[11]),
		.det_dn(src[12]), .det_up(src[13]), .mod_clk_dly(src[14]), .mod_core_clk(src[15]),
		.strobe_int_wr(src[16]), .strobe_frac_wr(src[17]), .strobe_aux_wr(src[18]),
		.ser_latch_en(src[19]), .div_sync_rst(src[20]), .seed_load(src[21]),
		.ser_out_en(src[22]), .soft_rst_n(src[23]));
	efgm_host_model host (.core_clk, .nrst, .start, .pattern, .ser_read_active(ser_act),
		.ser_data_out(ser_dat));
	////////////////////////////////////////////////////////////////////////////////
	always #5 core_clk = ~core_clk;
	// Cut a hung run short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(negedge core_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [23:0] exp);
		@(negedge core_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		@(negedge core_clk);
		check(reg_rdata, exp);
	endtask
	// Sum the divide values over n back-to-back comparison ticks
	task automatic ticks(input int n);
		sum = 0;
		@(negedge core_clk);
		pfd_tick = 1'b1; // One tick per 10 ns cycle keeps the rate at 100MHz
		repeat (n) begin
			@(negedge core_clk);
			if (div_valid === 1'b1) sum += fb_ratio;
		end
		pfd_tick = 1'b0;
	endtask
	// Source position feeding each select code, -1 when none
	function automatic int src_idx(input int c);
		case (c)
			1, 2: return c - 1;
			4, 5, 6: return c - 2;
			8: return 5;
			30, 31: return c - 8;
			default: return (c >= 10 && c <= 25) ? c - 4 : -1;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int idx;
		logic [23:0] mask;
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		check(pin_oe_n, 1'b1);
		rd(8'h0c, 24'h000000);
		rd(8'h0f, 24'h000001);
		rd(8'h2a, 24'h000000);
		wr(8'h0c, 24'hffffff);
		rd(8'h0c, 24'h003fff);
		// Addressed read with the driver otherwise off
		pattern = 8'ha5;
		@(negedge core_clk);
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		repeat (4) @(negedge core_clk);
		check(pin_oe_n, 1'b0);
		repeat (6) @(negedge core_clk);
		check(pin_oe_n, 1'b1);
		// Every select code with driver forced on
		for (int c = 0; c < 32; c++) begin
			for (int v = 0; v < 2; v++) begin
				idx = src_idx(c);
				mask = (idx >= 0) ? 24'h000001 << idx : 24'h000000;
				wr(8'h0f, 24'h000080 | (24'(v) << 5) | 24'(c));
				src = v ? mask : ~mask;
				@(negedge core_clk);
				check(pin_out, (idx < 0 && c != 0) ? 1'b0 : 1'(v));
				check(pin_oe_n, 1'b0);
			end
		end
		// Status readback: lock high, test bit low on a driven pin, two flops of delay
		wr(8'h0f, 24'h000180);
		src = 24'h000001;
		repeat (3) @(negedge core_clk);
		rd(8'h12, 24'h000002);
		check({pfet_off, nfet_off}, 2'h2);
		rd(8'h0f, 24'h000180);
		// Ratio set for an even output divide of 4
		// Exact mode: 44 + 108/255 over any 255 ticks
		fb_frac = 24'h6c6c6d;
		wr(8'h0c, 24'd255);
		ticks(600);
		ticks(255);
		check(sum, 32'd11328);
		fb_frac = 24'hffffff;
		wr(8'h0c, 24'd2);
		ticks(10);
		ticks(20);
		check(sum, 32'd890);
		wr(8'h0c, 24'd1);
		ticks(40);
		ticks(20);
		check(sum >= 32'd899, 1'b1);
		end_of_test();
	end
endmodule
